// [swd_pkg.sv]
// package for the software watchdog: register offsets, field positions,
// reset values, unlock keys and timing constants.
// assumes a 32-bit avalon-mm register bus with byte addresses.
package swd_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] SWD_OFF_CONTROL = 8'h00;
   localparam logic [7:0] SWD_OFF_SERVICE = 8'h10;
   localparam logic [7:0] SWD_OFF_STATUS = 8'h04;
   localparam logic [7:0] SWD_OFF_TIMEOUT = 8'h08;
   localparam logic [7:0] SWD_OFF_COUNT = 8'h0C;
   localparam logic [7:0] SWD_OFF_IRQ_STAT = 8'h14;
   localparam logic [7:0] SWD_OFF_IRQ_EN = 8'h18;
   localparam logic [7:0] SWD_OFF_IRQ_CLR = 8'h1C;

   // ****************************************
   // control fields and reset values
   // ****************************************
   localparam int SWD_CTL_EN_BIT = 0;
   localparam int SWD_CTL_LOCK_BIT = 4;
   localparam logic [31:0] SWD_CTL_RESET = 32'h0000_0001;
   localparam logic [31:0] SWD_CTL_WMASK = 32'hFF00_FFFE;

   // ****************************************
   // service keys
   // ****************************************
   localparam logic [15:0] SWD_KEY_FIRST = 16'hC520;
   localparam logic [15:0] SWD_KEY_SECOND = 16'hD928;
   localparam logic [15:0] SWD_KEY_MASK = 16'hFFFF;

   // ****************************************
   // timing and interrupt layout
   // ****************************************
   localparam logic [31:0] SWD_TIMEOUT_RESET = 32'h0000_1000;
   localparam int SWD_RESET_PULSE_CYCLES = 16;
   localparam int SWD_IRQ_BITS = 3;
   localparam int SWD_IRQ_EXPIRE = 0;
   localparam int SWD_IRQ_UNLOCK = 1;
   localparam int SWD_IRQ_BADKEY = 2;
   localparam logic [31:0] SWD_RDATA_UNMAPPED = 32'h0000_0000;

   typedef enum logic [1:0] {
      SWD_KEY_IDLE,
      SWD_KEY_GOT_FIRST
   } swd_key_state_t;

endpackage

// [swd_reset_pulse.sv]
// reset pulse stretcher: turns a one-cycle expiry into a fixed-width
// system reset request held in a register.
// assumes sys_clk and async active-low rstn.
`timescale 1ns/1ps
module swd_reset_pulse #(
   parameter int CYCLES = swd_pkg::SWD_RESET_PULSE_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic trigger,
   output logic resetReq
);
   import swd_pkg::*;

   logic [7:0] left;

   // load the counter on trigger, count down to zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         left <= 8'h00;
      end else if (trigger) begin
         left <= 8'(CYCLES);
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end

   // request follows the trigger and stands while the counter is above one
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         resetReq <= 1'b0;
      end else begin
         resetReq <= trigger || (left > 8'h01);
      end
   end

   pulse_len_a : assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(resetReq) |-> resetReq [*8])
      else $error("reset request shorter than expected");

endmodule // swd_reset_pulse

// [swd_watchdog.sv]
// software watchdog top: avalon-mm register slave, down counter,
// key sequence unlock, system reset request and interrupt.
// assumes a single clock sys_clk, async active-low rstn, and a master
// that holds each request until waitrequest is seen low.
`timescale 1ns/1ps

// Summary of operation
// [R1] while enabled the counter must be serviced, otherwise its first expiry requests a system reset.
// [R2] writing the first key then the second key to the service register clears the soft lock.
// [R3] once unlocked, clearing the enable bit in control stops the counter and servicing is no longer needed.
// [R4] the service register is a 32-bit write target at byte offset 0x10.
// [R5] the control register holding enable and configuration sits at byte offset 0.
// [R6] without the ordered key pair the lock stays set and control writes are ignored.
module swd_watchdog (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   output logic sysResetReq
);
   import swd_pkg::*;

   // ****************************************
   // bus handshake
   // ****************************************
   logic accepted;
   logic wrStrobe;
   logic rdStrobe;
   logic fullWord;

   // one wait state: answer on the second cycle of each request
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         accepted <= 1'b0;
      end else begin
         accepted <= (read || write) && !accepted;
      end
   end

   // waitrequest is low only in the cycle the request completes
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !((read || write) && !accepted);
      end
   end

   assign wrStrobe = write && accepted;
   assign rdStrobe = read && accepted;
   assign fullWord = (byteenable == 4'hF);

   // ****************************************
   // key sequence and soft lock
   // ****************************************
   swd_key_state_t keyState;
   logic softLock;
   logic svcWrite;
   logic firstKey;
   logic secondKey;
   logic unlockEvt;
   logic badKeyEvt;
   logic serviceEvt;
   logic ctlWrite;

   assign svcWrite = wrStrobe && (address == SWD_OFF_SERVICE) && fullWord; // R4
   assign firstKey = svcWrite && ((writedata[15:0] & SWD_KEY_MASK) == SWD_KEY_FIRST);
   assign secondKey = svcWrite && ((writedata[15:0] & SWD_KEY_MASK) == SWD_KEY_SECOND);
   assign unlockEvt = secondKey && (keyState == SWD_KEY_GOT_FIRST);
   assign serviceEvt = unlockEvt;
   assign badKeyEvt = svcWrite && !firstKey && !unlockEvt;

   // track the ordered pair; anything else restarts the sequence
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         keyState <= SWD_KEY_IDLE;
      end else if (svcWrite) begin
         case (keyState)
            SWD_KEY_IDLE: begin
               keyState <= firstKey ? SWD_KEY_GOT_FIRST : SWD_KEY_IDLE; // R2
            end
            SWD_KEY_GOT_FIRST: begin
               keyState <= firstKey ? SWD_KEY_GOT_FIRST : SWD_KEY_IDLE; // R2
            end
            default: begin
               keyState <= SWD_KEY_IDLE;
            end
         endcase
      end
   end

   // lock clears on the pair and is set again by a control write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         softLock <= 1'b1;
      end else if (unlockEvt) begin
         softLock <= 1'b0; // R2
      end else if (ctlWrite && !softLock) begin
         softLock <= 1'b1; // R6
      end
   end

   // ****************************************
   // control and timeout registers
   // ****************************************
   logic [31:0] control;
   logic [31:0] timeoutVal;
   logic enabled;

   assign ctlWrite = wrStrobe && (address == SWD_OFF_CONTROL) && fullWord; // R5
   assign enabled = control[SWD_CTL_EN_BIT];

   // control writes take effect only while unlocked
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         control <= SWD_CTL_RESET;
      end else if (ctlWrite && !softLock) begin
         control <= {writedata[31:1] & SWD_CTL_WMASK[31:1], writedata[SWD_CTL_EN_BIT]}; // R3 R6
      end
   end

   // timeout reload value, also guarded by the lock
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         timeoutVal <= SWD_TIMEOUT_RESET;
      end else if (wrStrobe && address == SWD_OFF_TIMEOUT && fullWord && !softLock) begin
         timeoutVal <= writedata; // R6
      end
   end

   // ****************************************
   // down counter and expiry
   // ****************************************
   logic [31:0] count;
   logic expireEvt;

   assign expireEvt = enabled && (count == 32'h0000_0000) && !serviceEvt;

   // count down while enabled; a valid pair reloads; disable parks the count
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count <= SWD_TIMEOUT_RESET;
      end else if (!enabled || serviceEvt) begin
         count <= timeoutVal; // R3
      end else if (count != 32'h0000_0000) begin
         count <= count - 32'h0000_0001; // R1
      end else begin
         count <= timeoutVal;
      end
   end

   swd_reset_pulse #(
      .CYCLES(SWD_RESET_PULSE_CYCLES)
   ) u_pulse (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .trigger(expireEvt), // R1
      .resetReq(sysResetReq)
   );

   // ****************************************
   // interrupts
   // ****************************************
   logic [SWD_IRQ_BITS-1:0] irqStat;
   logic [SWD_IRQ_BITS-1:0] irqEn;
   logic [SWD_IRQ_BITS-1:0] irqEvt;
   logic [SWD_IRQ_BITS-1:0] irqClr;

   assign irqEvt = {badKeyEvt, unlockEvt, expireEvt};
   assign irqClr = (wrStrobe && address == SWD_OFF_IRQ_CLR) ? writedata[SWD_IRQ_BITS-1:0] : '0;

   // sticky bits; a set in the clear cycle wins
   genvar gi;
   generate
      for (gi = 0; gi < SWD_IRQ_BITS; gi++) begin : g_irq
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               irqStat[gi] <= 1'b0;
            end else if (irqEvt[gi]) begin
               irqStat[gi] <= 1'b1;
            end else if (irqClr[gi]) begin
               irqStat[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // interrupt enable register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irqEn <= '0;
      end else if (wrStrobe && address == SWD_OFF_IRQ_EN) begin
         irqEn <= writedata[SWD_IRQ_BITS-1:0];
      end
   end

   // level interrupt from registered state
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat & irqEn);
      end
   end

   // ****************************************
   // read data
   // ****************************************
   logic [31:0] next_readdata;

   // read mux; service and clear registers read as zero
   always_comb begin
      next_readdata = SWD_RDATA_UNMAPPED;
      case (address)
         SWD_OFF_CONTROL: next_readdata = control;
         SWD_OFF_STATUS: next_readdata = {27'h0, softLock, 2'h0, keyState == SWD_KEY_GOT_FIRST, enabled};
         SWD_OFF_TIMEOUT: next_readdata = timeoutVal;
         SWD_OFF_COUNT: next_readdata = count;
         SWD_OFF_IRQ_STAT: next_readdata = {29'h0, irqStat};
         SWD_OFF_IRQ_EN: next_readdata = {29'h0, irqEn};
         default: next_readdata = SWD_RDATA_UNMAPPED;
      endcase
   end

   // data stand when waitrequest drops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         readdata <= 32'h0000_0000;
      end else if (read && !accepted) begin
         readdata <= next_readdata;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // steps of the unlock handshake
   sequence firstArm_s;
      firstKey && keyState == SWD_KEY_IDLE;
   endsequence

   sequence pairDone_s;
      secondKey && keyState == SWD_KEY_GOT_FIRST;
   endsequence

   expire_reset_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R1
      expireEvt |=> sysResetReq)
      else $error("expiry did not raise reset");

   count_runs_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R1
      (enabled && !serviceEvt && count != 32'h0 && $past(enabled)) |=> count == $past(count) - 32'h1)
      else $error("counter not decrementing");

   unlock_pair_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R2
      pairDone_s |=> !softLock && keyState == SWD_KEY_IDLE)
      else $error("lock not cleared by key pair");

   first_arms_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R2
      firstArm_s |=> keyState == SWD_KEY_GOT_FIRST)
      else $error("first key did not arm the sequence");

   pair_order_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R2
      $fell(softLock) |-> $past(keyState) == SWD_KEY_GOT_FIRST && $past(secondKey))
      else $error("lock cleared without ordered pair");

   disable_stops_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R3
      (!enabled && !$past(enabled)) |-> !expireEvt && count == $past(timeoutVal))
      else $error("disabled watchdog still counting");

   expire_irq_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R1
      expireEvt |=> irqStat[SWD_IRQ_EXPIRE])
      else $error("expiry not recorded in status");

   unlocked_write_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R3
      (ctlWrite && !softLock) |=> enabled == $past(writedata[SWD_CTL_EN_BIT]))
      else $error("unlocked control write lost");

   service_decode_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R4
      (wrStrobe && address == SWD_OFF_SERVICE && byteenable == 4'hF && writedata[15:0] == SWD_KEY_FIRST)
      |=> keyState == SWD_KEY_GOT_FIRST)
      else $error("service decode wrong");

   control_decode_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R5
      !(wrStrobe && address == SWD_OFF_CONTROL && byteenable == 4'hF) |=> $stable(control))
      else $error("control decode wrong");

   partial_ignore_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R5
      (wrStrobe && byteenable != 4'hF) |=> $stable(control) && $stable(timeoutVal))
      else $error("partial word write took effect");

   locked_ignore_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R6
      (ctlWrite && softLock) |=> control == $past(control))
      else $error("locked control write took effect");

   badkey_relock_a : assert property (@(posedge sys_clk) disable iff (!rstn) // R6
      (softLock && badKeyEvt) |=> softLock && keyState == SWD_KEY_IDLE)
      else $error("lock released without key pair");

endmodule // swd_watchdog

// [swd_watchdog_test.sv]
// self-checking bench for the software watchdog: bus tasks, key table, expiry.
// assumes swd_pkg and swd_watchdog are compiled before this file.
`timescale 1ns/1ps
module swd_watchdog_test;
   import swd_pkg::*;
   // ****************************************
   // signals and counters
   // ****************************************
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   logic sysResetReq;
   logic sawReset = 1'b0;
   logic [31:0] rd;
   logic [31:0] val;
   logic [15:0] keys [3];
   int fails = 0;
   int compares = 0;
   int seed = 32'hf1a0368d;
   int n;

   // 250 MHz system clock
   always #2 sys_clk = ~sys_clk;

   swd_watchdog i_dut (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .address(address),
      .read(read),
      .write(write),
      .writedata(writedata),
      .byteenable(byteenable),
      .readdata(readdata),
      .waitrequest(waitrequest),
      .irq(irq),
      .sysResetReq(sysResetReq)
   );

   // remember any system reset request since the last bench reset
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sawReset <= 1'b0;
      end else if (sysResetReq === 1'b1) begin
         sawReset <= 1'b1;
      end
   end

   // ****************************************
   // tasks and expectation model
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one avalon transfer, held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do begin
         @(posedge sys_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 64);
      if (k >= 64) fails++;
      check(k, 2);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic do_reset();
      rstn <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
   endtask

   task automatic unlock();
      bus(1'b1, SWD_OFF_SERVICE, {16'h0000, SWD_KEY_FIRST});
      bus(1'b1, SWD_OFF_SERVICE, {16'h0000, SWD_KEY_SECOND});
   endtask

   // lock state after three service writes: only first-then-second clears it
   function automatic logic lock_after(input logic [15:0] k [3]);
      logic first = 1'b0;
      logic lk = 1'b1;
      foreach (k[i]) begin
         if (k[i] == SWD_KEY_SECOND && first) lk = 1'b0;
         first = (k[i] == SWD_KEY_FIRST);
      end
      return lk;
   endfunction

   // a bad key is any service write that neither arms nor completes the pair
   function automatic logic bad_after(input logic [15:0] k [3]);
      logic first = 1'b0;
      logic bad = 1'b0;
      foreach (k[i]) begin
         if (k[i] != SWD_KEY_FIRST && !(k[i] == SWD_KEY_SECOND && first)) bad = 1'b1;
         first = (k[i] == SWD_KEY_FIRST);
      end
      return bad;
   endfunction

   task automatic report_and_stop();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      do_reset();
      check({31'h0, irq}, 32'h0000_0000);
      check({31'h0, sysResetReq}, 32'h0000_0000);
      bus(1'b0, SWD_OFF_CONTROL, 32'h0000_0000);
      check(rd, SWD_CTL_RESET);
      val = $random(seed);
      bus(1'b0, {2'b11, val[5:2], 2'b00}, 32'h0000_0000);
      check(rd, SWD_RDATA_UNMAPPED);
      // keys sent to another address leave the lock set
      bus(1'b1, SWD_OFF_IRQ_STAT, {16'h0000, SWD_KEY_FIRST});
      bus(1'b1, SWD_OFF_IRQ_STAT, {16'h0000, SWD_KEY_SECOND});
      bus(1'b0, SWD_OFF_STATUS, 32'h0000_0000);
      check(rd & 32'h0000_0010, 32'h0000_0010);
      // key table: corners first, then random mixes
      for (int t = 0; t < 14; t++) begin
         do_reset();
         for (int j = 0; j < 3; j++) begin
            val = $random(seed);
            if (val[15:0] == SWD_KEY_FIRST || val[15:0] == SWD_KEY_SECOND) val[15:0] = 16'h1234;
            keys[j] = (val[17:16] == 2'd0) ? SWD_KEY_FIRST : (val[17:16] == 2'd1) ? SWD_KEY_SECOND : val[15:0];
         end
         if (t == 0) keys = '{SWD_KEY_FIRST, SWD_KEY_SECOND, 16'h0000};
         if (t == 1) keys = '{SWD_KEY_SECOND, SWD_KEY_FIRST, 16'hFFFF};
         if (t == 2) keys = '{SWD_KEY_FIRST, 16'h5A5A, SWD_KEY_SECOND};
         if (t == 3) keys = '{SWD_KEY_FIRST, SWD_KEY_FIRST, SWD_KEY_SECOND};
         foreach (keys[j]) bus(1'b1, SWD_OFF_SERVICE, {16'h0000, keys[j]});
         bus(1'b0, SWD_OFF_STATUS, 32'h0000_0000);
         check(rd & 32'h0000_0010, {27'h0, lock_after(keys), 4'h0});
         bus(1'b0, SWD_OFF_IRQ_STAT, 32'h0000_0000);
         check(rd & 32'h0000_0006, {29'h0, bad_after(keys), ~lock_after(keys), 1'b0});
         bus(1'b1, SWD_OFF_CONTROL, 32'hFF00_010A);
         bus(1'b0, SWD_OFF_CONTROL, 32'h0000_0000);
         check(rd & 32'h0000_0001, {31'h0, lock_after(keys)});
      end
      // disable after unlock: no expiry over more than one timeout
      do_reset();
      bus(1'b1, SWD_OFF_IRQ_EN, 32'h0000_0002);
      unlock();
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0000_0001);
      // a partial word write to control is ignored even while unlocked
      byteenable <= 4'h1;
      bus(1'b1, SWD_OFF_CONTROL, 32'hFF00_010A);
      byteenable <= 4'hF;
      bus(1'b0, SWD_OFF_CONTROL, 32'h0000_0000);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      bus(1'b1, SWD_OFF_CONTROL, 32'hFF00_010A);
      bus(1'b0, SWD_OFF_CONTROL, 32'h0000_0000);
      check(rd & 32'h0000_0001, 32'h0000_0000);
      repeat (6000) @(posedge sys_clk);
      check({31'h0, sawReset}, 32'h0000_0000);
      bus(1'b0, SWD_OFF_COUNT, 32'h0000_0000);
      check(rd, SWD_TIMEOUT_RESET);
      // periodic servicing with the key pair keeps the system alive
      do_reset();
      for (int s = 0; s < 4; s++) begin
         val = $random(seed);
         repeat (2000 + val[9:0]) @(posedge sys_clk);
         unlock();
      end
      check({31'h0, sawReset}, 32'h0000_0000);
      // unserviced expiry: reset request, pulse width, interrupt and clear
      do_reset();
      n = 0;
      while (sysResetReq !== 1'b1 && n < 6000) begin
         @(posedge sys_clk);
         n++;
      end
      check({31'h0, (n >= 4090 && n <= 4105)}, 32'h0000_0001);
      n = 0;
      while (sysResetReq === 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      check(n, SWD_RESET_PULSE_CYCLES);
      bus(1'b0, SWD_OFF_IRQ_STAT, 32'h0000_0000);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      bus(1'b1, SWD_OFF_IRQ_EN, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0000_0001);
      bus(1'b1, SWD_OFF_IRQ_CLR, 32'h0000_0007);
      repeat (2) @(posedge sys_clk);
      check({31'h0, irq}, 32'h0000_0000);
      report_and_stop();
   end

   // cut a hang short well beyond the expected run length
   initial begin
      #(4 * 80000);
      fails++;
      report_and_stop();
   end
endmodule // swd_watchdog_test
